// ==== dv/sps_drive_model.sv ====
// drive model: read clock and serial read data of the disk unit
// assumes readClockControl from the search block turns the head on
`timescale 1ns/1ps
module sps_drive_model (
  input  wire logic readClockControl, // head on from block
  output logic      driveReadClock,   // read clock to block
  output logic      driveReadData     // read data to block
);
  localparam int         ZERO_RUN = 300;   // zero run ahead of sync byte
  localparam logic [5:0] SYNC     = 6'h33; // sync byte, msb first
  int                    n;                // cell index in the frame
  ////////////////////////////////////////////////////////////////////////
  // clock stands still off-frame; idle data toggles so no stale value shows
  initial begin
    driveReadClock = 1'b0;
    driveReadData = 1'b0;
    n = 0;
    forever begin
      if (readClockControl === 1'b1) begin
        driveReadData = (n >= ZERO_RUN && n < ZERO_RUN + 6) ? SYNC[ZERO_RUN + 5 - n] : 1'b0;
        n++;
        #100 driveReadClock = 1'b1;
        #100 driveReadClock = 1'b0;
      end else begin
        n = 0;
        driveReadData = ~driveReadData;
        #37;
      end
    end
  end
endmodule

// ==== dv/sps_pattern_search_bench.sv ====
// testbench: registers, director sequence and abort of the search block
// assumes the drive model answers once readClockControl is up
`timescale 1ns/1ps
module sps_pattern_search_bench;
  logic        clk, rst, regWr, regRd, directorExecPulse, readDirectorPartial, sectorMark; // inputs
  logic [7:0]  regAddr;       // register address
  logic [31:0] regWrData, directorWord, regRdData;
  logic        driveReadClock, driveReadData, patternDirectorDecode, directorDone, fault, headOnRequest;
  logic        driveControl, readClockControl, controlSelect, patternSearchActive, readEndPulse, compareEqual;
  logic        lowByteSelect, compareMuxUpper, checkwordPrecond, checkwordClkEn, specificModeActive, patternAbort;
  logic [15:0] writeDataBus;  // pattern routed to write bus
  int          nErrors, samplesChecked;
  sps_pattern_search DUT (.clk, .rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .directorWord,
    .directorExecPulse, .readDirectorPartial, .patternDirectorDecode, .directorDone, .fault, .driveReadClock,
    .driveReadData, .sectorMark, .headOnRequest, .driveControl, .readClockControl, .controlSelect,
    .patternSearchActive, .readInProgress(), .readProgressTwo(), .readProgressTwoAlt(), .readEndPulse,
    .regfileOntoWbus(), .writeDataBus, .lowByteSelect, .compareMuxUpper, .shiftMuxUpper(), .compareEqual,
    .checkwordPrecond, .checkwordClkEn, .specificModeActive, .patternAbort);
  sps_drive_model drive (.readClockControl, .driveReadClock, .driveReadData);
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic finalReport;
    if (nErrors == 0 && samplesChecked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      nErrors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk(name, exp, regRdData & m);
  endtask
  task automatic ex(input logic [31:0] w);
    @(posedge clk);
    directorWord <= w;
    readDirectorPartial <= 1'b1;
    directorExecPulse <= 1'b1;
    @(posedge clk);
    directorExecPulse <= 1'b0;
    #1;
  endtask
  // bounded wait for done (0) or abort (1)
  task automatic waitFor(input int which);
    for (int i = 0; i < 20000; i++) begin
      @(posedge clk);
      #1;
      if ((which == 0 ? directorDone : patternAbort) === 1'b1) return;
    end
    nErrors++;
    $display("[ERR] wait%0d expected 1 seen 0", which);
    finalReport();
  endtask
  // director word, bit n of the director at [31-n], bits 03 and 04 set
  function automatic logic [31:0] dw(input logic u, h, a, p, m, t, input logic [2:0] c, input logic [3:0] f);
    dw = 32'h1800_0000;
    dw[31 - sps_pkg::DB_UPPER] = u;
    dw[31 - sps_pkg::DB_HEAD] = h;
    dw[31 - sps_pkg::DB_ANY] = a;
    dw[31 - sps_pkg::DB_PRESET] = p;
    dw[31 - sps_pkg::DB_MISMATCH] = m;
    dw[31 - sps_pkg::DB_WAIT] = t;
    dw[6:4] = c;
    dw[3:0] = f;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, regAddr, regWrData, regWr, regRd, directorWord, directorExecPulse} = {1'b1, 75'h0};
    {readDirectorPartial, sectorMark, nErrors, samplesChecked} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd("status", sps_pkg::ADDR_STAT, 32'h0000_0000, 32'hFFFF_FFFF);
    rd("unmapped", 8'h3C, 32'h0000_0000, 32'hFFFF_FFFF);
    wr(8'h48, 32'h0000_5A00);
    wr(8'h44, 32'h0000_3300);
    wr(sps_pkg::ADDR_CTRL, 32'h0000_0001);
    rd("file", 8'h48, 32'h0000_5A00, 32'hFFFF_FFFF);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      directorWord <= {3'h0, k[1], k[0], 27'h0};
      readDirectorPartial <= k[2];
      #1 chk("decode", k == 7, patternDirectorDecode);
    end
    ex(dw(0, 1, 1, 0, 0, 1, 3'h0, 4'h2));
    chk("first", 32'h1F, {patternSearchActive, checkwordPrecond, headOnRequest, driveControl, readClockControl});
    chk("wbus", {2'b10, 16'h5A00}, {lowByteSelect, compareMuxUpper, writeDataBus});
    waitFor(0);
    ex(dw(0, 0, 1, 1, 1, 0, 3'h0, 4'h2));
    chk("keep", 1, patternSearchActive);
    waitFor(0);
    ex(dw(1, 0, 0, 0, 0, 0, 3'h0, 4'h1));
    chk("upper", {2'b11, 16'h3300}, {specificModeActive, compareMuxUpper, writeDataBus});
    waitFor(0);
    chk("cwclk", 3'b101, {checkwordClkEn, patternAbort, compareEqual});
    ex(32'h0000_0000);
    chk("cleared", 0, {patternSearchActive, specificModeActive});
    chk("readend", 1, readEndPulse);
    ex(dw(0, 1, 1, 0, 0, 1, 3'h0, 4'h2));
    sectorMark <= 1'b1;
    repeat (4) @(posedge clk);
    sectorMark <= 1'b0;
    waitFor(1);
    chk("abort", 2'b10, {fault, checkwordPrecond});
    rd("stat", sps_pkg::ADDR_STAT, 32'h0000_0038, 32'h0000_0038);
    wr(sps_pkg::ADDR_CTRL, 32'h0000_0003);
    @(posedge clk);
    #1 chk("clear", 0, {fault, patternAbort});
    // specific director against a byte that never passes by
    ex(dw(1, 0, 0, 0, 0, 0, 3'h0, 4'h2));
    waitFor(1);
    chk("miss", 3'b110, {fault, patternAbort, checkwordClkEn});
    finalReport();
  end
endmodule

// ==== logic/sps_pattern_search.sv ====
// address-pattern search: bit and byte sync on the drive read stream
// assumes director word and exec pulse come from logic on clk;
// drive read clock, read data and sector mark are asynchronous pins
//
// Overview of operation
// - pattern decode is partial read decode plus bits 03,04
// - exec pulse on pattern director sets precondition
// - exec pulse catches bits 15, 21-24 as options
// - exec pulse loads bits 28-31 as file address
// - pattern flag raises read in progress and gates
// - pattern flag routes file entry onto write bus
// - bit 15 picks upper or lower pattern byte
// - bit 16 turns on drive head and read clock; the block does so only while the control select line is enabled
// - two shift phases from read clock, counter, shift
// - next director waits for done before executing; the block takes any exec pulse at once unless faulted
// - wait option: two count-three clocks before compare
// - compare time gates equality of shift and pattern
// - equal mode: done, clear counter, clear-anyplace flag
// - mismatch mode: done when equality drops
// - preset option loads count 25-27 after success
// - load flag clears on following shift clock
// - pattern flag clears on non-pattern exec pulse
// - specific mode: count three sets checkword clock enable
// - specific count four: done if equal else abort
// - abort clears checkword flags, posts status, faults
// - exec after specific done clears pattern and specific
// - sector mark during search sets abort
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module sps_pattern_search #(
  parameter int RF_DEPTH = sps_pkg::RF_DEPTH  // pattern file entries
) (
  input  wire logic        clk,                   // 40 MHz clock
  input  wire logic        rst,                   // sync reset, high
  input  wire logic [7:0]  regAddr,               // register byte address
  input  wire logic [31:0] regWrData,             // register write data
  input  wire logic        regWr,                 // write strobe
  input  wire logic        regRd,                 // read strobe
  output logic      [31:0] regRdData,             // read data, next cycle
  input  wire logic [31:0] directorWord,          // director register
  input  wire logic        directorExecPulse,     // director exec pulse
  input  wire logic        readDirectorPartial,   // read director decode
  output logic             patternDirectorDecode, // pattern decode
  output logic             directorDone,          // done pulse
  output logic             fault,                 // fault, stops director
  input  wire logic        driveReadClock,        // drive read clock pin
  input  wire logic        driveReadData,         // drive read data pin
  input  wire logic        sectorMark,            // sector mark pin
  output logic             headOnRequest,         // head on pulse
  output logic             driveControl,          // drive control flag
  output logic             readClockControl,      // read clock control
  output logic             controlSelect,         // control select line
  output logic             patternSearchActive,   // pattern flag
  output logic             readInProgress,        // read in progress
  output logic             readProgressTwo,       // read data gate
  output logic             readProgressTwoAlt,    // checkword read mode
  output logic             readEndPulse,          // read end pulse
  output logic             regfileOntoWbus,       // file onto write bus
  output logic      [15:0] writeDataBus,          // write data bus
  output logic             lowByteSelect,         // lower byte picked
  output logic             compareMuxUpper,       // compare mux upper
  output logic             shiftMuxUpper,         // shift mux upper
  output logic             compareEqual,          // equality, gated
  output logic             checkwordPrecond,      // precondition flag
  output logic             checkwordClkEn,        // checkword clock en
  output logic             specificModeActive,    // specific flag
  output logic             patternAbort           // abort flag
);

  ////////////////////////////////////////////////////////////////////
  // state
  logic [15:0] rf_ff [RF_DEPTH];  // pattern file
  logic [15:0] nxt_rf [RF_DEPTH];
  logic [2:0] rclkSync_ff, nxt_rclkSync;  // read clock sync + edge
  logic [1:0] dataSync_ff, nxt_dataSync;  // read data sync
  logic [2:0] secSync_ff, nxt_secSync;  // sector mark sync + edge
  logic phaseB_ff, nxt_phaseB;  // second shift phase
  logic catch_ff, nxt_catch;  // read data catch bit
  logic [7:0] shift_ff, nxt_shift;  // shift register
  logic [2:0] bitCnt_ff, nxt_bitCnt;  // cell counter
  logic [2:0] presetCnt_ff, nxt_presetCnt;  // bit count catch
  logic loadBc_ff, nxt_loadBc;  // preset load flag
  logic [3:0] rfAddr_ff, nxt_rfAddr;  // file address counter
  logic optUpper_ff, nxt_optUpper;  // caught bit 15
  logic optAny_ff, nxt_optAny;  // caught bit 21
  logic optPreset_ff, nxt_optPreset;  // caught bit 22
  logic optMis_ff, nxt_optMis;  // caught bit 23
  logic optWait_ff, nxt_optWait;  // caught bit 24
  sps_pkg::sps_phase_t phase_ff, nxt_phase;  // anyplace window
  logic clrAny_ff, nxt_clrAny;  // clear-anyplace flag
  logic active_ff, nxt_active;  // pattern flag
  logic spec_ff, nxt_spec;  // specific flag
  logic specDone_ff, nxt_specDone;  // specific completed
  logic cwPre_ff, nxt_cwPre;  // checkword precondition
  logic cwClk_ff, nxt_cwClk;  // checkword clock enable
  logic abort_ff, nxt_abort;  // abort flag
  logic fault_ff, nxt_fault;  // fault flag
  logic drive_ff, nxt_drive;  // drive control
  logic rclkCtl_ff, nxt_rclkCtl;  // read clock control
  logic ctlSel_ff, nxt_ctlSel;  // control select
  logic done_ff, nxt_done;  // done pulse
  logic headOn_ff, nxt_headOn;  // head on pulse
  logic rdEnd_ff, nxt_rdEnd;  // read end pulse
  logic [31:0] rdData_ff, nxt_rdData;  // read data

  ////////////////////////////////////////////////////////////////////
  // combinational helpers
  logic phaseA;  // first shift phase
  logic sectorEdge;  // sector mark rise
  logic decode;  // pattern director decode
  logic [7:0] selByte;  // chosen pattern byte
  logic match;  // raw shift equals pattern
  logic doneNow;  // pattern done this cycle
  logic abortNow;  // abort this cycle
  logic execTaken;  // exec pulse accepted
  logic [15:0] rfWord;  // addressed file entry
  logic [31:0] statWord;  // status view

  // director bit by its doc number, bit 00 is the msb
  function automatic logic dbit(input logic [31:0] w, input int n);
    return w[sps_pkg::DIR_W - 1 - n];
  endfunction

  // read clock rise, sampled after two flops; first flop untouched
  assign phaseA = rclkSync_ff[1] & ~rclkSync_ff[2] & rclkCtl_ff;
  assign sectorEdge = secSync_ff[1] & ~secSync_ff[2];
  // decode requires both director bits 03 and 04 set
  assign decode = readDirectorPartial & dbit(directorWord, sps_pkg::DB_DEC_A)
                  & dbit(directorWord, sps_pkg::DB_DEC_B);
  assign rfWord = rf_ff[rfAddr_ff];
  // upper byte when caught bit 15 is one
  assign selByte = optUpper_ff ? rfWord[15:8] : rfWord[7:0];
  assign match = (shift_ff == selByte);
  // fault stops director execution, so pulses are ignored then
  assign execTaken = directorExecPulse & ~fault_ff;

  ////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    nxt_rf = rf_ff;
    nxt_rclkSync = {rclkSync_ff[1:0], driveReadClock};
    nxt_dataSync = {dataSync_ff[0], driveReadData};
    nxt_secSync = {secSync_ff[1:0], sectorMark};
    nxt_phaseB = phaseA;
    nxt_catch = catch_ff;
    nxt_shift = shift_ff;
    nxt_bitCnt = bitCnt_ff;
    nxt_presetCnt = presetCnt_ff;
    nxt_loadBc = loadBc_ff;
    nxt_rfAddr = rfAddr_ff;
    nxt_optUpper = optUpper_ff;
    nxt_optAny = optAny_ff;
    nxt_optPreset = optPreset_ff;
    nxt_optMis = optMis_ff;
    nxt_optWait = optWait_ff;
    nxt_phase = phase_ff;
    nxt_clrAny = clrAny_ff;
    nxt_active = active_ff;
    nxt_spec = spec_ff;
    nxt_specDone = specDone_ff;
    nxt_cwPre = cwPre_ff;
    nxt_cwClk = cwClk_ff;
    nxt_abort = abort_ff;
    nxt_fault = fault_ff;
    nxt_drive = drive_ff;
    nxt_rclkCtl = rclkCtl_ff;
    nxt_ctlSel = ctlSel_ff;
    nxt_done = 1'b0;
    nxt_headOn = 1'b0;
    nxt_rdData = sps_pkg::RD_ZERO;
    doneNow = 1'b0;
    abortNow = 1'b0;
    compareEqual = 1'b0;

    // equality shows only while a compare gate is open
    if (phase_ff == sps_pkg::PH_CMP || spec_ff) begin
      compareEqual = match;
    end

    // read clock rise: catch data, drive the anyplace window
    if (phaseA) begin
      nxt_catch = dataSync_ff[1];
      // load flag lives for one shift clock only
      if (loadBc_ff) begin
        nxt_loadBc = 1'b0;
      end
      // clear-anyplace is precleared on the next shift clock
      if (clrAny_ff) begin
        nxt_clrAny = 1'b0;
      end
      if (active_ff && !spec_ff) begin
        case (phase_ff)
          sps_pkg::PH_ARM: begin
            // wait option spends one extra byte to flush residue
            if (bitCnt_ff == sps_pkg::BIT_THREE) begin
              nxt_phase = optWait_ff ? sps_pkg::PH_FULL : sps_pkg::PH_CMP;
            end
          end
          sps_pkg::PH_FULL: begin
            // second count three opens compare, drops full byte
            if (bitCnt_ff == sps_pkg::BIT_THREE) begin
              nxt_phase = sps_pkg::PH_CMP;
            end
          end
          sps_pkg::PH_CMP: begin
            // equal mode wants a match, mismatch mode its loss
            if (optMis_ff ? !match : match) begin
              doneNow = 1'b1;
              nxt_bitCnt = sps_pkg::BIT_ZERO;
              nxt_clrAny = 1'b1;
              nxt_phase = sps_pkg::PH_IDLE;
              nxt_loadBc = optPreset_ff;
            end
          end
          default: begin
            nxt_phase = sps_pkg::PH_IDLE;  // idle until next director
          end
        endcase
      end
      // specific mode: byte boundary check at counts three and four
      if (spec_ff && !specDone_ff) begin
        if (bitCnt_ff == sps_pkg::BIT_THREE) begin
          nxt_cwClk = 1'b1;
        end
        if (bitCnt_ff == sps_pkg::BIT_FOUR && cwClk_ff) begin
          if (match) begin
            doneNow = 1'b1;
            nxt_specDone = 1'b1;
          end else begin
            abortNow = 1'b1;
          end
        end
      end
    end

    // second phase shifts the catch bit and counts the cell
    if (phaseB_ff) begin
      nxt_shift = {shift_ff[6:0], catch_ff};
      if (loadBc_ff) begin
        nxt_bitCnt = presetCnt_ff;
      end else begin
        nxt_bitCnt = bitCnt_ff + sps_pkg::BIT_STEP;
      end
    end

    // a sector mark anywhere in the sequence is fatal
    if (sectorEdge && active_ff) begin
      abortNow = 1'b1;
    end

    // exec pulse: start, continue or end the pattern sequence
    if (execTaken) begin
      if (specDone_ff || !decode) begin
        // any director after a finished specific ends the search
        nxt_active = 1'b0;
        nxt_spec = 1'b0;
        nxt_specDone = 1'b0;
        nxt_phase = sps_pkg::PH_IDLE;
        nxt_cwClk = 1'b0;
        nxt_drive = 1'b0;
        nxt_rclkCtl = 1'b0;
      end else begin
        nxt_cwPre = 1'b1;
        nxt_optUpper = dbit(directorWord, sps_pkg::DB_UPPER);
        nxt_optAny = dbit(directorWord, sps_pkg::DB_ANY);
        nxt_optPreset = dbit(directorWord, sps_pkg::DB_PRESET);
        nxt_optMis = dbit(directorWord, sps_pkg::DB_MISMATCH);
        nxt_optWait = dbit(directorWord, sps_pkg::DB_WAIT);
        nxt_presetCnt = directorWord[sps_pkg::DIR_W - 1 - sps_pkg::DB_CNT -: 3];
        nxt_rfAddr = directorWord[sps_pkg::DIR_W - 1 - sps_pkg::DB_RF -: 4];
        nxt_active = 1'b1;
        nxt_spec = !dbit(directorWord, sps_pkg::DB_ANY);
        nxt_phase = dbit(directorWord, sps_pkg::DB_ANY) ? sps_pkg::PH_ARM : sps_pkg::PH_IDLE;
        // head on only through an enabled control select line
        if (dbit(directorWord, sps_pkg::DB_HEAD) && ctlSel_ff) begin
          nxt_headOn = 1'b1;
          nxt_drive = 1'b1;
          nxt_rclkCtl = 1'b1;
        end
      end
    end

    // abort: drop checkword flags, post status, raise fault
    if (abortNow) begin
      nxt_abort = 1'b1;
      nxt_fault = 1'b1;
      nxt_cwPre = 1'b0;
      nxt_cwClk = 1'b0;
    end
    nxt_done = doneNow;

    // status view of the block's own state
    statWord = sps_pkg::RD_ZERO;
    statWord[sps_pkg::ST_ACTIVE] = active_ff;
    statWord[sps_pkg::ST_SPEC] = spec_ff;
    statWord[sps_pkg::ST_CMP] = (phase_ff == sps_pkg::PH_CMP);
    statWord[sps_pkg::ST_ABORT] = abort_ff;
    statWord[sps_pkg::ST_FAULT] = fault_ff;
    statWord[sps_pkg::ST_COMPOSITE] = abort_ff;
    statWord[sps_pkg::ST_DRIVE] = drive_ff;

    // register writes; the clear loses to a same-cycle abort
    if (regWr) begin
      if (regAddr == sps_pkg::ADDR_CTRL) begin
        nxt_ctlSel = regWrData[sps_pkg::CTL_SEL];
        if (regWrData[sps_pkg::CTL_CLR] && !abortNow) begin
          nxt_abort = 1'b0;
          nxt_fault = 1'b0;
        end
      end else if (regAddr[7:6] == sps_pkg::RF_PAGE && regAddr[1:0] == 2'h0) begin
        nxt_rf[regAddr[5:2]] = regWrData[15:0];
      end
    end

    // register reads; unmapped addresses answer zero
    if (regRd) begin
      if (regAddr == sps_pkg::ADDR_CTRL) begin
        nxt_rdData = {31'h0000_0000, ctlSel_ff};
      end else if (regAddr == sps_pkg::ADDR_STAT) begin
        nxt_rdData = statWord;
      end else if (regAddr == sps_pkg::ADDR_SHIFT) begin
        nxt_rdData = {21'h00_0000, bitCnt_ff, shift_ff};
      end else if (regAddr[7:6] == sps_pkg::RF_PAGE && regAddr[1:0] == 2'h0) begin
        nxt_rdData = {16'h0000, rf_ff[regAddr[5:2]]};
      end
    end

    // read end fires as the read in progress drops
    nxt_rdEnd = active_ff & ~nxt_active;
  end

  ////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < RF_DEPTH; i++) begin
        rf_ff[i] <= sps_pkg::RF_RESET;
      end
      rclkSync_ff <= 3'h0;
      dataSync_ff <= 2'h0;
      secSync_ff <= 3'h0;
      phaseB_ff <= 1'b0;
      catch_ff <= 1'b0;
      shift_ff <= sps_pkg::SHIFT_RESET;
      bitCnt_ff <= sps_pkg::BIT_ZERO;
      presetCnt_ff <= sps_pkg::BIT_ZERO;
      loadBc_ff <= 1'b0;
      rfAddr_ff <= 4'h0;
      optUpper_ff <= 1'b0;
      optAny_ff <= 1'b0;
      optPreset_ff <= 1'b0;
      optMis_ff <= 1'b0;
      optWait_ff <= 1'b0;
      phase_ff <= sps_pkg::PH_IDLE;
      clrAny_ff <= 1'b0;
      active_ff <= 1'b0;
      spec_ff <= 1'b0;
      specDone_ff <= 1'b0;
      cwPre_ff <= 1'b0;
      cwClk_ff <= 1'b0;
      abort_ff <= 1'b0;
      fault_ff <= 1'b0;
      drive_ff <= 1'b0;
      rclkCtl_ff <= 1'b0;
      ctlSel_ff <= 1'b0;
      done_ff <= 1'b0;
      headOn_ff <= 1'b0;
      rdEnd_ff <= 1'b0;
      rdData_ff <= sps_pkg::RD_ZERO;
    end else begin
      rf_ff <= nxt_rf;
      rclkSync_ff <= nxt_rclkSync;
      dataSync_ff <= nxt_dataSync;
      secSync_ff <= nxt_secSync;
      phaseB_ff <= nxt_phaseB;
      catch_ff <= nxt_catch;
      shift_ff <= nxt_shift;
      bitCnt_ff <= nxt_bitCnt;
      presetCnt_ff <= nxt_presetCnt;
      loadBc_ff <= nxt_loadBc;
      rfAddr_ff <= nxt_rfAddr;
      optUpper_ff <= nxt_optUpper;
      optAny_ff <= nxt_optAny;
      optPreset_ff <= nxt_optPreset;
      optMis_ff <= nxt_optMis;
      optWait_ff <= nxt_optWait;
      phase_ff <= nxt_phase;
      clrAny_ff <= nxt_clrAny;
      active_ff <= nxt_active;
      spec_ff <= nxt_spec;
      specDone_ff <= nxt_specDone;
      cwPre_ff <= nxt_cwPre;
      cwClk_ff <= nxt_cwClk;
      abort_ff <= nxt_abort;
      fault_ff <= nxt_fault;
      drive_ff <= nxt_drive;
      rclkCtl_ff <= nxt_rclkCtl;
      ctlSel_ff <= nxt_ctlSel;
      done_ff <= nxt_done;
      headOn_ff <= nxt_headOn;
      rdEnd_ff <= nxt_rdEnd;
      rdData_ff <= nxt_rdData;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs
  assign regRdData = rdData_ff;
  assign patternDirectorDecode = decode;
  assign directorDone = done_ff;
  assign fault = fault_ff;
  assign headOnRequest = headOn_ff;
  assign driveControl = drive_ff;
  assign readClockControl = rclkCtl_ff;
  assign controlSelect = ctlSel_ff;
  assign patternSearchActive = active_ff;
  // the pattern flag opens the read path as a whole
  assign readInProgress = active_ff;
  assign readProgressTwo = active_ff;
  assign readProgressTwoAlt = active_ff;
  assign readEndPulse = rdEnd_ff;
  // the bus is quiet unless a search owns it
  assign regfileOntoWbus = active_ff;
  assign writeDataBus = active_ff ? rfWord : 16'h0000;
  assign lowByteSelect = active_ff & ~optUpper_ff;
  assign compareMuxUpper = active_ff & optUpper_ff;
  assign shiftMuxUpper = active_ff & optUpper_ff;
  assign checkwordPrecond = cwPre_ff;
  assign checkwordClkEn = cwClk_ff;
  assign specificModeActive = spec_ff;
  assign patternAbort = abort_ff;

  ////////////////////////////////////////////////////////////////////
  // checks
  chk_start_flags: assert property (@(posedge clk) disable iff (rst)
    execTaken && decode && !specDone_ff && !abortNow |=> active_ff && cwPre_ff)
    else $error("pattern director did not set flags");
  chk_active_clear: assert property (@(posedge clk) disable iff (rst)
    execTaken && !decode |=> !active_ff && !readInProgress)
    else $error("pattern flag kept on other director");
  chk_wbus_route: assert property (@(posedge clk) disable iff (rst)
    active_ff |-> regfileOntoWbus && writeDataBus == rf_ff[rfAddr_ff])
    else $error("file entry not on write bus");
  chk_shift_phase: assert property (@(posedge clk) disable iff (rst)
    phaseA |=> phaseB_ff ##1 shift_ff[0] == $past(catch_ff))
    else $error("catch bit not shifted on phase b");
  chk_done_clear: assert property (@(posedge clk) disable iff (rst)
    doneNow && !spec_ff |=> clrAny_ff && bitCnt_ff == sps_pkg::BIT_ZERO ##1 directorDone == 1'b0)
    else $error("anyplace done did not clear counter");
  chk_wait_byte: assert property (@(posedge clk) disable iff (rst)
    phase_ff == sps_pkg::PH_FULL && phaseA && bitCnt_ff == sps_pkg::BIT_THREE
    && !execTaken |=> phase_ff == sps_pkg::PH_CMP)
    else $error("second count three did not open compare");
  chk_spec_abort: assert property (@(posedge clk) disable iff (rst)
    spec_ff && !specDone_ff && cwClk_ff && phaseA && bitCnt_ff == sps_pkg::BIT_FOUR
    && !match |=> patternAbort && fault && !checkwordClkEn && !checkwordPrecond)
    else $error("specific miss did not abort");
  chk_sector_abort: assert property (@(posedge clk) disable iff (rst)
    sectorEdge && active_ff |=> patternAbort && fault)
    else $error("sector mark did not abort");
  chk_spec_end: assert property (@(posedge clk) disable iff (rst)
    execTaken && specDone_ff |=> !active_ff && !spec_ff)
    else $error("exec after specific did not end search");
  // the cleared counter must not survive a preset load
  chk_preset_load: assert property (@(posedge clk) disable iff (rst)
    loadBc_ff && phaseB_ff |=> bitCnt_ff == $past(presetCnt_ff))
    else $error("preset count not loaded");
  chk_load_drop: assert property (@(posedge clk) disable iff (rst)
    loadBc_ff && phaseA |=> !loadBc_ff)
    else $error("load flag outlived one shift clock");

endmodule

// ==== logic/sps_pkg.sv ====
// constants, field positions and types of the address-pattern search block
// assumes director bit 00 is the most significant bit of the director word
package sps_pkg;
  // bus geometry
  localparam int DIR_W = 32;  // director word width
  localparam int RF_DEPTH = 16;  // register file entries
  localparam int RF_W = 16;  // register file entry width
  localparam int AW = 8;  // register bus address width
  localparam int DW = 32;  // register bus data width
  // register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;  // control
  localparam logic [7:0] ADDR_STAT = 8'h04;  // status
  localparam logic [7:0] ADDR_SHIFT = 8'h08;  // shift register view
  localparam logic [1:0] RF_PAGE = 2'h1;  // addr[7:6] of pattern file
  // control bits
  localparam int CTL_SEL = 0;  // control select line enable
  localparam int CTL_CLR = 1;  // write one: clear abort and fault
  // status bits
  localparam int ST_ACTIVE = 0;
  localparam int ST_SPEC = 1;
  localparam int ST_CMP = 2;
  localparam int ST_ABORT = 3;
  localparam int ST_FAULT = 4;
  localparam int ST_COMPOSITE = 5;
  localparam int ST_DRIVE = 6;
  // director bit numbers, bit 00 is the msb
  localparam int DB_DEC_A = 3;
  localparam int DB_DEC_B = 4;
  localparam int DB_UPPER = 15;
  localparam int DB_HEAD = 16;
  localparam int DB_ANY = 21;
  localparam int DB_PRESET = 22;
  localparam int DB_MISMATCH = 23;
  localparam int DB_WAIT = 24;
  localparam int DB_CNT = 25;  // 25..27, 25 is msb
  localparam int DB_RF = 28;  // 28..31, 28 is msb
  // bit counter marks
  localparam logic [2:0] BIT_THREE = 3'h3;
  localparam logic [2:0] BIT_FOUR = 3'h4;
  localparam logic [2:0] BIT_ZERO = 3'h0;
  localparam logic [2:0] BIT_STEP = 3'h1;
  // reset values
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  localparam logic [15:0] RF_RESET = 16'h0000;
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  // compare window phases, gray along arm, full byte, compare
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ARM  = 2'b01,
    PH_FULL = 2'b11,
    PH_CMP  = 2'b10
  } sps_phase_t;
endpackage
